// [logic/core_registers.sv]
/*
 * Programmer-visible register set and condition flag logic of the core.
 * Interrupt entry and return touch only the mask pair, flags and counter;
 * branch_taken is decoded combinationally from the registered flags.
 * Assumes the sequencer asserts req.valid for one cycle when an instruction
 * completes and supplies the operand, new PC and pushed or loaded values.
 */
`timescale 1ns/1ps
`default_nettype none
module core_registers
(
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire core_regs_pkg::op_req_s  req,
    input  wire core_regs_pkg::cond_e    cond_sel,
    output logic                         branch_taken,
    output core_regs_pkg::core_view_s    view,
    output logic [7:0]                   result,
    output logic [7:0]                   mul_high
);
    import core_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        core_view_s regs;
        logic [7:0] result;
        logic [7:0] mul_high;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic cond_true(input cond_e c, input logic [7:0] f);
        case (c)
            COND_HALF:      cond_true = f[FLAG_HALF];
            COND_NO_HALF:   cond_true = !f[FLAG_HALF];
            COND_MINUS:     cond_true = f[FLAG_NEG];
            COND_PLUS:      cond_true = !f[FLAG_NEG];
            COND_EQUAL:     cond_true = f[FLAG_ZERO];
            COND_NOT_EQUAL: cond_true = !f[FLAG_ZERO];
            COND_CARRY:     cond_true = f[FLAG_CARRY];
            COND_NO_CARRY:  cond_true = !f[FLAG_CARRY];
            COND_ALWAYS:    cond_true = 1'b1;
            default:        cond_true = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Nine bit add or subtract; bit 8 is carry or borrow
    function automatic logic [8:0] add_sub9(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci, input logic sub);
        if (sub)
        begin
            add_sub9 = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        end
        else
        begin
            add_sub9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Carry out of the low nibble
    function automatic logic nibble_carry(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
        logic [4:0] n;
        n            = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        nibble_carry = n[4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Loads the interrupt mask pair, high bit first
    function automatic logic [7:0] put_mask(input logic [7:0] f, input logic [1:0] m);
        put_mask                 = f;
        put_mask[FLAG_MASK_HIGH] = m[1];
        put_mask[FLAG_MASK_LOW]  = m[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shift or rotate by one; carry out above the result
    function automatic logic [8:0] shift_one(input op_e o, input logic [7:0] a, input logic ci);
        case (o)
            OP_SLL:  shift_one = {a, 1'b0};
            OP_SRL:  shift_one = {a[0], 1'b0, a[7:1]};
            OP_RLC:  shift_one = {a, ci};
            default: shift_one = {a[0], ci, a[7:1]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Branch decision on the current flags
    assign branch_taken = cond_true(cond_sel, st.regs.condition_flags);
    assign view         = st.regs;
    assign result       = st.result;
    assign mul_high     = st.mul_high;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  src;
    logic [8:0]  sum;
    logic        new_h;
    logic [15:0] prod;
    logic [7:0]  res;
    logic        carry_in;
    logic        upd_nz;
    logic        upd_c;
    logic        upd_h;
    logic        new_c;
    logic        wr_res;

    always_comb
    begin
        next_st  = st;
        // Source: accumulator, or the index register the prefix selects
        src      = req.prefix ? st.regs.index_y : st.regs.index_x;
        if (req.dst == DST_ACC)
        begin
            src = st.regs.acc;
        end
        carry_in = st.regs.condition_flags[FLAG_CARRY];
        sum      = 9'h000;
        new_h    = 1'b0;
        prod     = 16'h0000;
        res      = src;
        upd_nz   = 1'b0;
        upd_c    = 1'b0;
        upd_h    = 1'b0;
        new_c    = 1'b0;
        wr_res   = 1'b0;
        // Nothing moves unless an instruction completes this cycle
        if (req.valid)
        begin
            next_st.regs.program_counter = req.next_pc;
            case (req.op)
                OP_ADD, OP_ADC:
                begin
                    sum    = add_sub9(src, req.operand, (req.op == OP_ADC) & carry_in, 1'b0);
                    new_h  = nibble_carry(src, req.operand, (req.op == OP_ADC) & carry_in);
                    res    = sum[7:0];
                    new_c  = sum[8];
                    upd_h  = 1'b1;
                    upd_c  = 1'b1;
                    upd_nz = 1'b1;
                    wr_res = 1'b1;
                end
                OP_SUB, OP_SBC, OP_CP:
                begin
                    sum    = add_sub9(src, req.operand, (req.op == OP_SBC) & carry_in, 1'b1);
                    res    = sum[7:0];
                    new_c  = sum[8];
                    upd_c  = 1'b1;
                    upd_nz = 1'b1;
                    wr_res = (req.op != OP_CP);
                end
                OP_AND, OP_OR, OP_XOR, OP_LD, OP_CPL:
                begin
                    case (req.op)
                        OP_AND:  res = src & req.operand;
                        OP_OR:   res = src | req.operand;
                        OP_XOR:  res = src ^ req.operand;
                        OP_LD:   res = req.operand;
                        default: res = ~src;
                    endcase
                    upd_nz = 1'b1;
                    wr_res = 1'b1;
                    if (req.op == OP_CPL)
                    begin
                        upd_c = 1'b1;
                        new_c = 1'b1;
                    end
                end
                OP_INCX:
                begin
                    res    = src + 8'h01;
                    upd_nz = 1'b1;
                    wr_res = 1'b1;
                end
                OP_SLL, OP_SRL, OP_RLC, OP_RRC:
                begin
                    {new_c, res} = shift_one(req.op, src, carry_in);
                    upd_c  = 1'b1;
                    upd_nz = 1'b1;
                    wr_res = 1'b1;
                end
                OP_MUL:
                begin
                    // High byte to the accumulator, low byte to the index
                    prod  = src * req.operand;
                    next_st.mul_high = prod[15:8];
                    res   = prod[7:0];
                    next_st.regs.acc = prod[15:8];
                    if (req.prefix)
                    begin
                        next_st.regs.index_y = prod[7:0];
                    end
                    else
                    begin
                        next_st.regs.index_x = prod[7:0];
                    end
                    next_st.result = prod[7:0];
                    next_st.regs.condition_flags[FLAG_HALF]  = 1'b0;
                    next_st.regs.condition_flags[FLAG_CARRY] = 1'b0;
                end
                OP_BTJ:
                begin
                    upd_c = 1'b1;
                    new_c = req.bit_value;
                end
                OP_SCF:
                begin
                    next_st.regs.condition_flags[FLAG_CARRY] = 1'b1;
                end
                OP_RCF:
                begin
                    next_st.regs.condition_flags[FLAG_CARRY] = 1'b0;
                end
                OP_SIM:
                begin
                    next_st.regs.condition_flags =
                        put_mask(st.regs.condition_flags, PRIO_LEVEL3);
                end
                OP_RIM:
                begin
                    next_st.regs.condition_flags =
                        put_mask(st.regs.condition_flags, PRIO_LEVEL0);
                end
                OP_IRQ_ENTRY:
                begin
                    next_st.regs.condition_flags =
                        put_mask(st.regs.condition_flags, req.sw_priority);
                end
                OP_POP_FLAGS, OP_IRQ_RETURN:
                begin
                    // Stack image restores all but the hardwired top pair
                    next_st.regs.condition_flags = req.pop_value | FLAGS_ONES;
                end
                default:
                begin
                    next_st.regs.condition_flags = st.regs.condition_flags;
                end
            endcase
            // Write back to the selected destination
            if (wr_res)
            begin
                next_st.result = res;
                case (req.dst)
                    DST_ACC:   next_st.regs.acc = res;
                    DST_INDEX:
                    begin
                        if (req.prefix)
                        begin
                            next_st.regs.index_y = res;
                        end
                        else
                        begin
                            next_st.regs.index_x = res;
                        end
                    end
                    default:   next_st.result = res;
                endcase
            end
            // Flag merge; flags not named keep their value
            if (upd_h)
            begin
                next_st.regs.condition_flags[FLAG_HALF] = new_h;
            end
            if (upd_nz)
            begin
                next_st.regs.condition_flags[FLAG_NEG]  = res[7];
                next_st.regs.condition_flags[FLAG_ZERO] = (res == 8'h00);
            end
            if (upd_c)
            begin
                next_st.regs.condition_flags[FLAG_CARRY] = new_c;
            end
            // Top bits are hardwired; index_y is never part of the context
            next_st.regs.condition_flags = next_st.regs.condition_flags | FLAGS_ONES;
            if (req.op == OP_IRQ_ENTRY || req.op == OP_IRQ_RETURN)
            begin
                next_st.regs.index_y = st.regs.index_y;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st.regs.acc             <= REG_RESET;
            st.regs.index_x         <= REG_RESET;
            st.regs.index_y         <= REG_RESET;
            st.regs.program_counter <= PC_RESET;
            st.regs.condition_flags <= FLAGS_RESET;
            st.result               <= REG_RESET;
            st.mul_high             <= REG_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // core_registers
`default_nettype wire

// [logic/core_regs_pkg.sv]
/*
 * Constants, operation codes and carrier structs for the core register set
 * and condition flag logic.
 * Assumes an instruction sequencer that presents one completed operation
 * per cycle on the op_req carrier.
 */
// Notes on behaviour
// - Six internal registers, not memory mapped, reached only by instructions; this block holds five: acc, index_x, index_y, program_counter, condition_flags.
// - Eight bit accumulator holds ALU operands and results.
// - Two eight bit index registers; prefix selects the second one.
// - Interrupt context save and restore never touch the second index register.
// - Sixteen bit program counter built from low and high byte registers.
// - Native fast eight by eight multiply.
// - Flags register eight bits, top two read one, reset 111x1xxx.
// - Flags register pushed and popped; each bit testable and controllable.
// - Half carry set on carry from bit 3 to 4 in add and add with carry.
// - Branches on half carry set or clear.
// - Negative flag, bit 2, copies result bit 7.
// - Branches on negative set or clear.
// - Zero flag, bit 1, set when result is zero.
// - Branches on zero set or clear.
// - Carry flag, bit 0, set on overflow or underflow.
// - Carry forced one or zero, tested, updated by shifts, rotates, bit tests.
// - Mask pair encodes priority: 10 level 0, 01 level 1, 00 level 2, 11 off.
// - Interrupt entry loads mask bits from priority registers; instructions may change them.
package core_regs_pkg;

    localparam int FLAG_CARRY    = 0;
    localparam int FLAG_ZERO     = 1;
    localparam int FLAG_NEG      = 2;
    localparam int FLAG_MASK_LOW = 3;
    localparam int FLAG_HALF     = 4;
    localparam int FLAG_MASK_HIGH = 5;

    localparam logic [7:0]  FLAGS_RESET   = 8'hf8;
    localparam logic [7:0]  FLAGS_ONES    = 8'hc0;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [7:0]  REG_RESET     = 8'h00;

    localparam logic [1:0] PRIO_LEVEL0 = 2'b10;
    localparam logic [1:0] PRIO_LEVEL1 = 2'b01;
    localparam logic [1:0] PRIO_LEVEL2 = 2'b00;
    localparam logic [1:0] PRIO_LEVEL3 = 2'b11;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_SBC = 5'h04, OP_AND = 5'h05, OP_OR  = 5'h06, OP_XOR = 5'h07,
        OP_LD  = 5'h08, OP_CPL = 5'h09, OP_SLL = 5'h0a, OP_SRL = 5'h0b,
        OP_RLC = 5'h0c, OP_RRC = 5'h0d, OP_MUL = 5'h0e, OP_CP  = 5'h0f,
        OP_SCF = 5'h10, OP_RCF = 5'h11, OP_SIM = 5'h12, OP_RIM = 5'h13,
        OP_POP_FLAGS = 5'h14, OP_IRQ_ENTRY = 5'h15, OP_IRQ_RETURN = 5'h16,
        OP_BTJ = 5'h17, OP_JUMP = 5'h18, OP_INCX = 5'h19
    } op_e;

    typedef enum logic [3:0] {
        COND_HALF = 4'h0, COND_NO_HALF = 4'h1, COND_MINUS = 4'h2, COND_PLUS = 4'h3,
        COND_EQUAL = 4'h4, COND_NOT_EQUAL = 4'h5, COND_CARRY = 4'h6,
        COND_NO_CARRY = 4'h7, COND_ALWAYS = 4'h8
    } cond_e;

    typedef enum logic [1:0] {
        DST_ACC = 2'b00, DST_INDEX = 2'b01, DST_NONE = 2'b10
    } dst_e;

    typedef struct packed {
        logic       valid;
        op_e        op;
        dst_e       dst;
        logic       prefix;
        logic [7:0] operand;
        logic [15:0] next_pc;
        logic [7:0] pop_value;
        logic [1:0] sw_priority;
        logic       bit_value;
    } op_req_s;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  index_x;
        logic [7:0]  index_y;
        logic [15:0] program_counter;
        logic [7:0]  condition_flags;
    } core_view_s;

endpackage

// [verification/core_registers_checker.sv]
/* Concurrent checks on the ports of the core register set.
   Assumes one clock domain and is bound onto core_registers. */
`timescale 1ns/1ps
`default_nettype none
module core_registers_checker
(
    input wire logic                      sys_clk,
    input wire logic                      rstn,
    input wire core_regs_pkg::op_req_s    req,
    input wire core_regs_pkg::cond_e      cond_sel,
    input wire logic                      branch_taken,
    input wire core_regs_pkg::core_view_s view,
    input wire logic [7:0]                result,
    input wire logic [7:0]                mul_high
);
    import core_regs_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence add_taken;
        req.valid && req.op == OP_ADD && req.dst == DST_ACC;
    endsequence
    sequence alu_taken;
        req.valid && req.op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_LD};
    endsequence
    sequence irq_taken;
        req.valid && req.op inside {OP_IRQ_ENTRY, OP_IRQ_RETURN};
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    top_ones_a: assert property (view.condition_flags[7:6] == 2'b11)
        else $error("flags top bits not one");
    half_carry_a: assert property (add_taken |=> view.condition_flags[FLAG_HALF] ==
        (({1'b0, $past(view.acc[3:0])} + {1'b0, $past(req.operand[3:0])}) > 5'd15))
        else $error("half carry wrong after add");
    neg_copy_a: assert property (alu_taken |=> view.condition_flags[FLAG_NEG] == result[7])
        else $error("negative flag not result bit 7");
    zero_flag_a: assert property (alu_taken |=> view.condition_flags[FLAG_ZERO] == (result == 0))
        else $error("zero flag wrong");
    idle_hold_a: assert property (!req.valid |=> $stable(view) && $stable(result))
        else $error("state moved without a request");
    carry_force_a: assert property (req.valid && req.op inside {OP_SCF, OP_RCF}
        |=> view.condition_flags[FLAG_CARRY] == ($past(req.op) == OP_SCF))
        else $error("carry not forced");
    irq_keeps_y_a: assert property (irq_taken |=> $stable(view.index_y))
        else $error("index y changed by interrupt context");
    irq_mask_load_a: assert property (req.valid && req.op == OP_IRQ_ENTRY |=>
        {view.condition_flags[FLAG_MASK_HIGH], view.condition_flags[FLAG_MASK_LOW]}
        == $past(req.sw_priority))
        else $error("mask pair not loaded on entry");
    pc_follow_a: assert property (req.valid |=> view.program_counter == $past(req.next_pc))
        else $error("program counter not updated");
    mul_flags_a: assert property (req.valid && req.op == OP_MUL |=>
        !view.condition_flags[FLAG_HALF] && !view.condition_flags[FLAG_CARRY])
        else $error("multiply left half carry or carry set");
    branch_eq_a: assert property (cond_sel == COND_EQUAL |->
        branch_taken == view.condition_flags[FLAG_ZERO])
        else $error("equal branch disagrees with zero flag");
endmodule // core_registers_checker

bind core_registers core_registers_checker u_chk
(
    .sys_clk(sys_clk), .rstn(rstn), .req(req), .cond_sel(cond_sel),
    .branch_taken(branch_taken), .view(view), .result(result), .mul_high(mul_high)
);
`default_nettype wire

// [verification/cpu_core_registers_and_flags_tb_top.sv]
/* Directed testbench for the core register set and condition flags.
   Assumes the design package is compiled first and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) cmp(n, 16'(e), 16'(g))
module cpu_core_registers_and_flags_tb_top;
    import core_regs_pkg::*;
    logic        sys_clk;
    logic        rstn;
    op_req_s     req;
    cond_e       cond_sel;
    logic        branch_taken;
    core_view_s  view;
    logic [7:0]  result;
    logic [7:0]  mul_high;
    logic [15:0] pc_next;
    int          fail_count;
    int          check_count;
    // Flag ops, their argument, bits looked at and expected pattern
    op_e         t_op[8]   = '{OP_RCF, OP_SCF, OP_BTJ, OP_IRQ_ENTRY, OP_SIM, OP_RIM, OP_POP_FLAGS,
                               OP_IRQ_RETURN};
    logic [7:0]  t_arg[8]  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h2a};
    logic [7:0]  t_mask[8] = '{8'h01, 8'h01, 8'h01, 8'h28, 8'h28, 8'h28, 8'hff, 8'hff};
    logic [7:0]  t_want[8] = '{8'h00, 8'h01, 8'h00, 8'h08, 8'h28, 8'h20, 8'hc0, 8'hea};
    // ALU ops: start value, operand, carry in, expected acc and H N Z C
    op_e         a_op[15]  = '{OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_XOR, OP_CPL,
                               OP_SLL, OP_SRL, OP_RLC, OP_RRC, OP_INCX, OP_NOP, OP_JUMP};
    logic [7:0]  a_in[15]  = '{8'h0f, 8'h10, 8'h05, 8'h33, 8'hf0, 8'h80, 8'haa, 8'h0f,
                               8'h81, 8'h01, 8'h40, 8'h02, 8'hff, 8'h7e, 8'h00};
    logic [7:0]  a_arg[15] = '{8'h00, 8'h20, 8'h04, 8'h33, 8'h3c, 8'h01, 8'haa, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic        a_ci[15]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                               1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0]  a_acc[15] = '{8'h10, 8'hf0, 8'h00, 8'h33, 8'h30, 8'h81, 8'h00, 8'hf0,
                               8'h02, 8'h00, 8'h81, 8'h81, 8'h00, 8'h7e, 8'h00};
    logic [7:0]  a_flg[15] = '{8'h10, 8'h15, 8'h12, 8'h12, 8'h11, 8'h14, 8'h13, 8'h15,
                               8'h11, 8'h13, 8'h14, 8'h14, 8'h13, 8'h10, 8'h13};

    core_registers DUT
    (
        .sys_clk(sys_clk), .rstn(rstn), .req(req), .cond_sel(cond_sel),
        .branch_taken(branch_taken), .view(view), .result(result), .mul_high(mul_high)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Presents one request; taken at the following edge
    task automatic do_op(input op_e o, input dst_e d, input logic p, input logic [7:0] v,
                         input logic [7:0] x);
        @(posedge sys_clk);
        pc_next = pc_next + 16'h0003;
        req <= '{valid: 1'b1, op: o, dst: d, prefix: p, operand: v, next_pc: pc_next,
                 pop_value: x, sw_priority: x[1:0], bit_value: x[0]};
    endtask

    // Lets the last request be taken, then waits till outputs settle
    task automatic settle();
        @(posedge sys_clk);
        req.valid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic br_all(input logic [7:0] f);
        logic [8:0] want;
        want = {1'b1, ~f[0], f[0], ~f[1], f[1], ~f[2], f[2], ~f[4], f[4]};
        for (int i = 0; i < 9; i++)
        begin
            @(posedge sys_clk);
            cond_sel <= cond_e'(i);
            @(negedge sys_clk);
            `CHK("branch_taken", want[i], branch_taken);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        rstn = 1'b0;
        req = '0;
        cond_sel = COND_ALWAYS;
        pc_next = 16'h0100;
        fail_count = 0;
        check_count = 0;
        repeat (12) @(posedge sys_clk);
        `CHK("flags_reset", 8'he8, view.condition_flags & 8'he8);
        `CHK("pc_reset", PC_RESET, view.program_counter);
        rstn <= 1'b1;
        do_op(OP_LD, DST_ACC, 1'b0, 8'h08, 8'h00);
        do_op(OP_ADD, DST_ACC, 1'b0, 8'h08, 8'h00);
        settle();
        `CHK("acc_add", 8'h10, view.acc);
        `CHK("flags_add", 8'hf8, view.condition_flags);
        `CHK("result_add", 8'h10, result);
        `CHK("pc_next", pc_next, view.program_counter);
        do_op(OP_ADD, DST_ACC, 1'b0, 8'hf0, 8'h00);
        settle();
        `CHK("acc_wrap", 8'h00, view.acc);
        `CHK("flags_wrap", 8'heb, view.condition_flags);
        br_all(8'heb);
        do_op(OP_LD, DST_ACC, 1'b0, 8'h80, 8'h00);
        settle();
        `CHK("flags_ld", 8'hed, view.condition_flags);
        br_all(8'hed);
        do_op(OP_LD, DST_INDEX, 1'b1, 8'h34, 8'h00);
        do_op(OP_LD, DST_ACC, 1'b0, 8'h12, 8'h00);
        do_op(OP_MUL, DST_INDEX, 1'b1, 8'h34, 8'h00);
        settle();
        `CHK("mul_acc", 8'h0a, view.acc);
        `CHK("mul_high", 8'h0a, mul_high);
        `CHK("mul_low_y", 8'h90, view.index_y);
        `CHK("index_x", REG_RESET, view.index_x);
        `CHK("mul_hc", 2'b00, {view.condition_flags[4], view.condition_flags[0]});
        foreach (t_op[i])
        begin
            do_op(t_op[i], DST_NONE, 1'b0, 8'h00, t_arg[i]);
            settle();
            `CHK("flag_op", t_want[i], view.condition_flags & t_mask[i]);
            `CHK("index_y_kept", 8'h90, view.index_y);
        end
        foreach (a_op[i])
        begin
            do_op(a_ci[i] ? OP_SCF : OP_RCF, DST_NONE, 1'b0, 8'h00, 8'h00);
            do_op(OP_LD, DST_ACC, 1'b0, a_in[i], 8'h00);
            do_op(a_op[i], DST_ACC, 1'b0, a_arg[i], 8'h00);
            settle();
            `CHK("alu_acc", a_acc[i], view.acc);
            `CHK("alu_flags", a_flg[i], view.condition_flags & 8'h17);
        end
        tally_and_finish();
    end
endmodule // cpu_core_registers_and_flags_tb_top
`default_nettype wire
